// [dps_cfg.svh]
// Function
// R1 - two independent ports access any word together
// R2 - controllers avoid same-word writes in one cycle
// R3 - latency select: low flow-through, high pipelined
// R4 - pipelined adds output register, flow-through bypasses
// R5 - selected only when low-select low, high-select high
// R6 - one deselected cycle enters low-power state
// R7 - pipelined reactivation needs one selected cycle first; the model drives the first read after deselect anyway
// R8 - address strobe low loads external address
// R9 - count enable low increments counter each edge
// R10 - load and clear override count enable
// R11 - counter clear zeroes counter, highest priority
// R12 - counter spans array, wraps to zero
// R13 - address twelve or thirteen bits, 18-bit words
// R14 - read/write select low writes, high reads
// R15 - byte selects gate the two 9-bit lanes
// R16 - lane driven only with byte select and output enable
// R17 - port clock may run free or be gated
// R18 - pipelined read data one cycle after flow-through
// R19 - counter works regardless of chip selects
// R20 - output enable asynchronous, others sampled on edge
// R21 - no counter control held: counter holds address
// R22 - data pins undriven while deselected or writing
`ifndef DPS_CFG_SVH
`define DPS_CFG_SVH

// ----------------------------------------------------------------
// array geometry (8K variant; 12 address bits for the 4K variant)
// ----------------------------------------------------------------
`define DPS_ADDR_W    13
`define DPS_DEPTH     8192
`define DPS_DATA_W    18
`define DPS_LANE_W    9
`define DPS_LANE_LO   0
`define DPS_LANE_HI   1
`define DPS_CNT_RST   13'h0000
`define DPS_DATA_RST  18'h00000

// ----------------------------------------------------------------
// host timing
// ----------------------------------------------------------------
`define DPS_LEN_W     8
`define DPS_TRACK_W   4
`define DPS_FT_TAP    2
`define DPS_PIPE_TAP  3

`endif

// [dps_pkg.sv]
`include "dps_cfg.svh"
`default_nettype none

package dps_pkg;

   typedef struct packed {
      logic [`DPS_ADDR_W-1:0] cnt;
      logic                   sel;
      logic                   rd;
      logic                   wr;
      logic [1:0]             lanes;
      logic                   pipe;
      logic [`DPS_DATA_W-1:0] wdata;
      logic [1:0]             mid_drv;
      logic [`DPS_DATA_W-1:0] mid_data;
      logic [1:0]             out_drv;
      logic [`DPS_DATA_W-1:0] out_data;
      logic                   pd;
   } dps_port_type;

   typedef struct packed {
      dps_port_type [1:0] p;
   } dps_dev_type;

   typedef enum logic [1:0] {
      DPS_IDLE,
      DPS_ISSUE,
      DPS_DRAIN
   } dps_hstate_type;

   typedef struct packed {
      dps_hstate_type          state;
      logic [`DPS_LEN_W-1:0]   rem;
      logic [`DPS_TRACK_W-1:0] track;
      logic                    clk_en;
      logic [`DPS_ADDR_W-1:0]  addr;
      logic                    ads_n;
      logic                    csl_n;
      logic                    csh;
      logic                    count_enable_n_n;
      logic                    clr_n;
      logic                    rd;
      logic                    lb_n;
      logic                    ub_n;
      logic                    oe_n;
      logic                    pipe;
      logic [`DPS_DATA_W-1:0]  wd;
      logic                    wd_oe;
      logic                    ready;
      logic                    rsp_valid;
      logic [`DPS_DATA_W-1:0]  rsp_data;
      logic                    done;
   } dps_host_type;

endpackage

`default_nettype wire

// [dps_port_if.sv]
`include "dps_cfg.svh"
`default_nettype none

interface dps_port_if;
   logic                   clk_en;
   logic [`DPS_ADDR_W-1:0] addr;
   logic                   address_strobe_n;
   logic                   chip_select_low_n;
   logic                   chip_select_high;
   logic                   count_enable_n;
   logic                   counter_clear_n;
   logic                   read_write;
   logic                   low_byte_sel_n;
   logic                   high_byte_sel_n;
   logic                   out_en_n;
   logic                   latency_mode_sel;
   logic [`DPS_DATA_W-1:0] host_dq;
   logic                   host_dq_oe;
   logic [`DPS_DATA_W-1:0] dev_dq;
   logic [1:0]             dev_dq_oe;
   logic                   power_down;
   wire  [`DPS_DATA_W-1:0] dq_bus;

   // ----------------------------------------------------------------
   // wire resolution per lane; undriven lanes read as zero
   // ----------------------------------------------------------------
   assign dq_bus[8:0]  = dev_dq_oe[0] ? dev_dq[8:0] :
                         (host_dq_oe ? host_dq[8:0] : 9'h000);
   assign dq_bus[17:9] = dev_dq_oe[1] ? dev_dq[17:9] :
                         (host_dq_oe ? host_dq[17:9] : 9'h000);

   modport mem (
      input  clk_en, addr, address_strobe_n, chip_select_low_n, chip_select_high,
             count_enable_n, counter_clear_n, read_write, low_byte_sel_n,
             high_byte_sel_n, out_en_n, latency_mode_sel, dq_bus,
      output dev_dq, dev_dq_oe, power_down
   );

   modport ctrl (
      output clk_en, addr, address_strobe_n, chip_select_low_n, chip_select_high,
             count_enable_n, counter_clear_n, read_write, low_byte_sel_n,
             high_byte_sel_n, out_en_n, latency_mode_sel, host_dq, host_dq_oe,
      input  dq_bus, power_down
   );
endinterface

`default_nettype wire

// [dps_mem.sv]
`include "dps_cfg.svh"
`default_nettype none

module dps_mem (
   input  wire logic mclk,        // system clock
   input  wire logic sys_rst,     // async reset, active high
   dps_port_if.mem   left_port,   // first port pins
   dps_port_if.mem   right_port,  // second port pins
   output logic      left_busy,   // left port selected last edge
   output logic      right_busy   // right port selected last edge
);

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic is_selected(input logic csl_n, input logic csh);
      is_selected = !csl_n && csh; // [R5]
   endfunction

   function automatic logic [`DPS_ADDR_W-1:0] next_count(
      input logic [`DPS_ADDR_W-1:0] cnt,
      input logic [`DPS_ADDR_W-1:0] ext,
      input logic                   clr_n,
      input logic                   ads_n,
      input logic                   count_enable_n_n);
      if (!clr_n) begin
         next_count = `DPS_CNT_RST; // [R11]
      end else if (!ads_n) begin
         next_count = ext; // [R8] [R10]
      end else if (!count_enable_n_n) begin
         next_count = cnt + `DPS_ADDR_W'(1); // [R9] [R12]
      end else begin
         next_count = cnt; // [R21]
      end
   endfunction

   // read lanes that may reach the pins; writes and idle cycles drive nothing
   function automatic logic [1:0] drive_lanes(input logic rd, input logic [1:0] lanes);
      drive_lanes = rd ? lanes : 2'b00; // [R16] [R22]
   endfunction

   function automatic logic [`DPS_DATA_W-1:0] merge_lanes(
      input logic [`DPS_DATA_W-1:0] old_w,
      input logic [`DPS_DATA_W-1:0] new_w,
      input logic [1:0]             lanes);
      merge_lanes = old_w;
      if (lanes[`DPS_LANE_LO]) begin
         merge_lanes[8:0] = new_w[8:0]; // [R15]
      end
      if (lanes[`DPS_LANE_HI]) begin
         merge_lanes[17:9] = new_w[17:9]; // [R15]
      end
   endfunction

   // ----------------------------------------------------------------
   // port inputs gathered so both ports share one loop
   // ----------------------------------------------------------------
   logic [1:0]                   en;
   logic [1:0][`DPS_ADDR_W-1:0]  ext_addr; // [R13]
   logic [1:0]                   ads_n;
   logic [1:0]                   csl_n;
   logic [1:0]                   csh;
   logic [1:0]                   count_enable_n_n;
   logic [1:0]                   clr_n;
   logic [1:0]                   rw;
   logic [1:0]                   lb_n;
   logic [1:0]                   ub_n;
   logic [1:0]                   mode;
   logic [1:0][`DPS_DATA_W-1:0]  din;
   logic [1:0][`DPS_DATA_W-1:0]  rd_word;

   assign en       = {right_port.clk_en, left_port.clk_en};
   assign ext_addr = {right_port.addr, left_port.addr};
   assign ads_n    = {right_port.address_strobe_n, left_port.address_strobe_n};
   assign csl_n    = {right_port.chip_select_low_n, left_port.chip_select_low_n};
   assign csh      = {right_port.chip_select_high, left_port.chip_select_high};
   assign count_enable_n_n  = {right_port.count_enable_n, left_port.count_enable_n};
   assign clr_n    = {right_port.counter_clear_n, left_port.counter_clear_n};
   assign rw       = {right_port.read_write, left_port.read_write};
   assign lb_n     = {right_port.low_byte_sel_n, left_port.low_byte_sel_n};
   assign ub_n     = {right_port.high_byte_sel_n, left_port.high_byte_sel_n};
   assign mode     = {right_port.latency_mode_sel, left_port.latency_mode_sel};
   assign din      = {right_port.dq_bus, left_port.dq_bus};

   // ----------------------------------------------------------------
   // storage: one array, both ports read it every cycle and write it on selected write cycles with clk_en high
   // ----------------------------------------------------------------
   logic [`DPS_DATA_W-1:0] mem [`DPS_DEPTH];
   dps_pkg::dps_dev_type   st_reg;
   dps_pkg::dps_dev_type   st_next;

   assign rd_word[0] = mem[st_reg.p[0].cnt]; // [R1]
   assign rd_word[1] = mem[st_reg.p[1].cnt]; // [R1]

   // same-word writes: right port lands last, value is not promised
   always_ff @(posedge mclk) begin
      for (int i = 0; i < 2; i++) begin
         if (en[i] && st_reg.p[i].wr) begin // [R14]
            mem[st_reg.p[i].cnt] <= merge_lanes(mem[st_reg.p[i].cnt],
                                                st_reg.p[i].wdata,
                                                st_reg.p[i].lanes); // [R1]
         end
      end
   end

   // ----------------------------------------------------------------
   // per-port pipeline
   // ----------------------------------------------------------------
   always_comb begin
      st_next = st_reg;
      for (int i = 0; i < 2; i++) begin
         // a stopped port clock freezes every stage of that port
         if (en[i]) begin // [R17]
            st_next.p[i].cnt = next_count(st_reg.p[i].cnt, ext_addr[i], clr_n[i],
                                          ads_n[i], count_enable_n_n[i]); // [R19]
            st_next.p[i].sel   = is_selected(csl_n[i], csh[i]); // [R20]
            st_next.p[i].rd    = st_next.p[i].sel && rw[i]; // [R14]
            st_next.p[i].wr    = st_next.p[i].sel && !rw[i]; // [R14]
            st_next.p[i].lanes = {!ub_n[i], !lb_n[i]}; // [R15]
            st_next.p[i].pipe  = mode[i]; // [R3]
            st_next.p[i].wdata = din[i];
            st_next.p[i].pd    = !st_next.p[i].sel; // [R6]
            if (st_reg.p[i].pipe) begin
               // extra register stage; a read on the first selected cycle after
               // deselect reaches the pins three edges later like any other read
               st_next.p[i].mid_drv  = drive_lanes(st_reg.p[i].rd, st_reg.p[i].lanes); // [R7]
               st_next.p[i].mid_data = rd_word[i]; // [R4]
               st_next.p[i].out_drv  = st_reg.p[i].mid_drv; // [R18]
               st_next.p[i].out_data = st_reg.p[i].mid_data; // [R4]
            end else begin
               st_next.p[i].mid_drv  = 2'b00;
               st_next.p[i].mid_data = rd_word[i];
               st_next.p[i].out_drv  = drive_lanes(st_reg.p[i].rd, st_reg.p[i].lanes); // [R22]
               st_next.p[i].out_data = rd_word[i]; // [R4]
            end
         end
      end
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         for (int i = 0; i < 2; i++) begin
            st_reg.p[i] <= '{cnt: `DPS_CNT_RST, sel: 1'b0, rd: 1'b0, wr: 1'b0,
                             lanes: 2'b00, pipe: 1'b0, wdata: `DPS_DATA_RST,
                             mid_drv: 2'b00, mid_data: `DPS_DATA_RST,
                             out_drv: 2'b00, out_data: `DPS_DATA_RST, pd: 1'b1};
         end
      end else begin
         st_reg <= st_next;
      end
   end

   // ----------------------------------------------------------------
   // pins; output enable gates the drivers without a clock
   // ----------------------------------------------------------------
   assign left_port.dev_dq     = st_reg.p[0].out_data;
   assign right_port.dev_dq    = st_reg.p[1].out_data;
   assign left_port.dev_dq_oe  = st_reg.p[0].out_drv & {2{!left_port.out_en_n}}; // [R16] [R20]
   assign right_port.dev_dq_oe = st_reg.p[1].out_drv & {2{!right_port.out_en_n}}; // [R16] [R20]
   assign left_port.power_down  = st_reg.p[0].pd; // [R6]
   assign right_port.power_down = st_reg.p[1].pd; // [R6]
   assign left_busy  = st_reg.p[0].sel;
   assign right_busy = st_reg.p[1].sel;

endmodule

`default_nettype wire

// [dps_host.sv]
`include "dps_cfg.svh"
`default_nettype none

module dps_host (
   input  wire logic                   mclk,        // system clock
   input  wire logic                   sys_rst,     // async reset, active high
   dps_port_if.ctrl                    port,        // memory port pins
   input  wire logic                   req_valid,   // request offered
   input  wire logic                   req_write,   // 1 write single word, 0 read burst
   input  wire logic                   req_clear,   // start at word zero via clear
   input  wire logic [`DPS_ADDR_W-1:0] req_addr,    // start address
   input  wire logic [`DPS_DATA_W-1:0] req_wdata,   // write word
   input  wire logic [1:0]             req_lanes_n, // lane selects, active low
   input  wire logic [`DPS_LEN_W-1:0]  req_len,     // read beats, 0 means 1
   input  wire logic                   pipe_mode,   // latency mode for next request
   output logic                        req_ready,   // idle, request taken
   output logic                        rsp_valid,   // read word pulse
   output logic [`DPS_DATA_W-1:0]      rsp_data,    // read word
   output logic                        done         // request finished pulse
);

   dps_pkg::dps_host_type q_reg;
   dps_pkg::dps_host_type q_next;
   logic                  issue_rd;
   logic                  tap;

   always_comb begin
      q_next           = q_reg;
      issue_rd         = 1'b0;
      q_next.done      = 1'b0;
      q_next.clk_en    = 1'b1; // [R17]
      tap = q_reg.pipe ? q_reg.track[`DPS_PIPE_TAP] : q_reg.track[`DPS_FT_TAP]; // [R18]
      q_next.rsp_valid = tap;
      q_next.rsp_data  = tap ? port.dq_bus : q_reg.rsp_data;
      unique case (q_reg.state)
         dps_pkg::DPS_IDLE: begin
            if (req_valid && q_reg.ready) begin
               q_next.ready   = 1'b0;
               q_next.pipe    = pipe_mode; // [R3]
               q_next.csl_n   = 1'b0; // [R5] [R7]
               q_next.csh     = 1'b1;
               q_next.addr    = req_addr;
               q_next.ads_n   = req_clear; // [R8]
               q_next.clr_n   = !req_clear; // [R11]
               q_next.count_enable_n_n = 1'b1;
               q_next.rd      = !req_write; // [R14]
               q_next.lb_n    = req_lanes_n[`DPS_LANE_LO]; // [R15]
               q_next.ub_n    = req_lanes_n[`DPS_LANE_HI];
               q_next.oe_n    = req_write; // [R16]
               // caller keeps write words apart from the other port
               q_next.wd      = req_wdata; // [R2]
               q_next.wd_oe   = req_write; // [R22]
               issue_rd       = !req_write;
               if (req_write || req_len <= `DPS_LEN_W'(1)) begin
                  q_next.rem   = '0;
                  q_next.state = dps_pkg::DPS_DRAIN;
               end else begin
                  q_next.rem   = req_len - `DPS_LEN_W'(1);
                  q_next.state = dps_pkg::DPS_ISSUE;
               end
            end
         end
         dps_pkg::DPS_ISSUE: begin
            q_next.ads_n   = 1'b1;
            q_next.clr_n   = 1'b1;
            q_next.count_enable_n_n = 1'b0; // [R9]
            issue_rd       = 1'b1;
            q_next.rem     = q_reg.rem - `DPS_LEN_W'(1);
            if (q_reg.rem == `DPS_LEN_W'(1)) begin
               q_next.state = dps_pkg::DPS_DRAIN;
            end
         end
         dps_pkg::DPS_DRAIN: begin
            // deselect parks the port in low power; counter holds
            q_next.csl_n   = 1'b1; // [R6]
            q_next.csh     = 1'b0;
            q_next.ads_n   = 1'b1;
            q_next.clr_n   = 1'b1;
            q_next.count_enable_n_n = 1'b1; // [R21]
            q_next.rd      = 1'b1;
            q_next.wd_oe   = 1'b0;
            q_next.oe_n    = 1'b0;
            if (q_reg.track[`DPS_TRACK_W-2:0] == '0) begin
               q_next.state = dps_pkg::DPS_IDLE;
               q_next.ready = 1'b1;
               q_next.done  = 1'b1;
            end
         end
         // the unused fourth code falls back to idle
         default: begin
            q_next.state = dps_pkg::DPS_IDLE;
            q_next.ready = 1'b1;
         end
      endcase
      q_next.track = {q_reg.track[`DPS_TRACK_W-2:0], issue_rd};
   end

   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         q_reg <= '{state: dps_pkg::DPS_IDLE, rem: '0, track: '0, clk_en: 1'b1,
                    addr: `DPS_CNT_RST, ads_n: 1'b1, csl_n: 1'b1, csh: 1'b0,
                    count_enable_n_n: 1'b1, clr_n: 1'b1, rd: 1'b1, lb_n: 1'b1, ub_n: 1'b1,
                    oe_n: 1'b1, pipe: 1'b0, wd: `DPS_DATA_RST, wd_oe: 1'b0,
                    ready: 1'b1, rsp_valid: 1'b0, rsp_data: `DPS_DATA_RST,
                    done: 1'b0};
      end else begin
         q_reg <= q_next;
      end
   end

   assign port.clk_en            = q_reg.clk_en;
   assign port.addr              = q_reg.addr;
   assign port.address_strobe_n  = q_reg.ads_n;
   assign port.chip_select_low_n = q_reg.csl_n;
   assign port.chip_select_high  = q_reg.csh;
   assign port.count_enable_n    = q_reg.count_enable_n_n;
   assign port.counter_clear_n   = q_reg.clr_n;
   assign port.read_write        = q_reg.rd;
   assign port.low_byte_sel_n    = q_reg.lb_n;
   assign port.high_byte_sel_n   = q_reg.ub_n;
   assign port.out_en_n          = q_reg.oe_n;
   assign port.latency_mode_sel  = q_reg.pipe;
   assign port.host_dq           = q_reg.wd;
   assign port.host_dq_oe        = q_reg.wd_oe;
   assign req_ready = q_reg.ready;
   assign rsp_valid = q_reg.rsp_valid;
   assign rsp_data  = q_reg.rsp_data;
   assign done      = q_reg.done;

endmodule

`default_nettype wire

// [dps_sva.sv]
`include "dps_cfg.svh"
`default_nettype none

module dps_sva (
   input wire logic       mclk,              // system clock
   input wire logic       sys_rst,           // async reset
   input wire logic       clk_en,            // port clock enable
   input wire logic       chip_select_low_n, // low active select
   input wire logic       chip_select_high,  // high active select
   input wire logic       read_write,        // 1 read, 0 write
   input wire logic       low_byte_sel_n,    // lane 0 select
   input wire logic       high_byte_sel_n,   // lane 1 select
   input wire logic       out_en_n,          // output enable
   input wire logic       latency_mode_sel,  // 1 pipelined
   input wire logic       host_dq_oe,        // host drives dq
   input wire logic [1:0] dev_dq_oe,         // device lane drive
   input wire logic       power_down         // deselected flag
);
   timeunit 1ns;
   timeprecision 1ps;

   logic sel;

   assign sel = !chip_select_low_n && chip_select_high;

   default clocking cb @(posedge mclk); endclocking
   default disable iff (sys_rst);

   // ----------------------------------------------------------------
   // select and power state
   // ----------------------------------------------------------------
   pd_on_desel_a: assert property (clk_en && !sel |=> power_down)
      else $error("power down missing after deselect");
   pd_off_sel_a: assert property (clk_en && sel |=> !power_down)
      else $error("power down while selected");
   gate_hold_a: assert property (!clk_en |=> $stable(power_down))
      else $error("state moved on a gated clock");

   // ----------------------------------------------------------------
   // data drivers
   // ----------------------------------------------------------------
   oe_gate_a: assert property (out_en_n |-> dev_dq_oe == 2'b00)
      else $error("lane driven with output enable off");
   no_fight_a: assert property (host_dq_oe |-> dev_dq_oe == 2'b00)
      else $error("device drives against host write data");
   wr_quiet_a: assert property (clk_en && sel && !read_write && !latency_mode_sel
      ##1 clk_en |=> dev_dq_oe == 2'b00)
      else $error("lane driven after a write");
   desel_ft_a: assert property (clk_en && !sel && !latency_mode_sel
      ##1 clk_en && !latency_mode_sel |=> dev_dq_oe == 2'b00)
      else $error("flow-through lane driven after deselect");
   desel_pipe_a: assert property (clk_en && !sel && latency_mode_sel
      ##1 (clk_en && latency_mode_sel)[*2] |=> dev_dq_oe == 2'b00)
      else $error("pipelined lane driven after deselect");
   rd_ft_a: assert property (clk_en && sel && read_write && !low_byte_sel_n
      && !latency_mode_sel ##1 clk_en && !latency_mode_sel |=> dev_dq_oe[0] == !out_en_n)
      else $error("flow-through read not driven two cycles on");
   rd_pipe_a: assert property (clk_en && sel ##1 clk_en && sel && read_write
      && !high_byte_sel_n && latency_mode_sel ##1 (clk_en && latency_mode_sel)[*2]
      |=> dev_dq_oe[1] == !out_en_n)
      else $error("pipelined read not driven three cycles on");
   lane_off_a: assert property (clk_en && sel && read_write && low_byte_sel_n
      && !latency_mode_sel ##1 clk_en && !latency_mode_sel |=> !dev_dq_oe[0])
      else $error("unselected lane driven");
endmodule

`default_nettype wire

// [tb_top.sv]
`include "dps_cfg.svh"
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic                   p;
      logic                   wr;
      logic                   clr;
      logic [`DPS_ADDR_W-1:0] addr;
      logic [`DPS_DATA_W-1:0] wd;
      logic [1:0]             ln;
      logic [7:0]             len;
      logic                   pipe;
   } dps_row_type;

   logic        mclk    = 1'b0;
   logic        sys_rst = 1'b1;
   dps_row_type rq [2];
   logic        vld [2];
   wire  [1:0]  rdy;
   wire  [1:0]  rv;
   wire  [1:0]  dn;
   wire  [1:0]  bsy;
   wire  [17:0] rd [2];
   logic [17:0] ref_mem [int];
   int          fail_count = 0;
   int          cmp_count  = 0;
   // p wr clr addr wd lanes_n len pipe; writes full words before any lane-only access
   dps_row_type rows [12] = '{
      '{1'b0, 1'b1, 1'b0, 13'h0010, 18'h2a5a5, 2'h0, 8'h00, 1'b0},
      '{1'b0, 1'b1, 1'b0, 13'h0011, 18'h11234, 2'h0, 8'h00, 1'b0},
      '{1'b1, 1'b1, 1'b0, 13'h1fff, 18'h3c0f0, 2'h0, 8'h00, 1'b1},
      '{1'b1, 1'b1, 1'b0, 13'h0000, 18'h0abcd, 2'h0, 8'h00, 1'b0},
      '{1'b0, 1'b0, 1'b0, 13'h0010, 18'h00000, 2'h0, 8'h02, 1'b0},
      '{1'b1, 1'b0, 1'b0, 13'h0010, 18'h00000, 2'h0, 8'h02, 1'b1},
      '{1'b0, 1'b1, 1'b0, 13'h0010, 18'h00777, 2'h2, 8'h00, 1'b0},
      '{1'b1, 1'b0, 1'b0, 13'h1fff, 18'h00000, 2'h0, 8'h02, 1'b0},
      '{1'b0, 1'b0, 1'b1, 13'h0123, 18'h00000, 2'h0, 8'h01, 1'b1},
      '{1'b1, 1'b0, 1'b0, 13'h0010, 18'h00000, 2'h2, 8'h01, 1'b0},
      '{1'b0, 1'b0, 1'b0, 13'h0010, 18'h00000, 2'h1, 8'h02, 1'b0},
      '{1'b0, 1'b0, 1'b0, 13'h0010, 18'h00000, 2'h0, 8'h02, 1'b1}
   };

   always #5 mclk = ~mclk;

   dps_port_if pif [2] ();

   dps_mem dps_mem_i (
      .mclk(mclk), .sys_rst(sys_rst), .left_port(pif[0]), .right_port(pif[1]),
      .left_busy(bsy[0]), .right_busy(bsy[1])
   );

   for (genvar g = 0; g < 2; g++) begin : g_host
      dps_host dps_host_i (
         .mclk(mclk), .sys_rst(sys_rst), .port(pif[g]), .req_valid(vld[g]),
         .req_write(rq[g].wr), .req_clear(rq[g].clr), .req_addr(rq[g].addr),
         .req_wdata(rq[g].wd), .req_lanes_n(rq[g].ln), .req_len(rq[g].len),
         .pipe_mode(rq[g].pipe), .req_ready(rdy[g]), .rsp_valid(rv[g]),
         .rsp_data(rd[g]), .done(dn[g])
      );
   end

   dps_sva dps_sva_i (
      .mclk(mclk), .sys_rst(sys_rst), .clk_en(pif[0].clk_en),
      .chip_select_low_n(pif[0].chip_select_low_n), .chip_select_high(pif[0].chip_select_high),
      .read_write(pif[0].read_write), .low_byte_sel_n(pif[0].low_byte_sel_n),
      .high_byte_sel_n(pif[0].high_byte_sel_n), .out_en_n(pif[0].out_en_n),
      .latency_mode_sel(pif[0].latency_mode_sel), .host_dq_oe(pif[0].host_dq_oe),
      .dev_dq_oe(pif[0].dev_dq_oe), .power_down(pif[0].power_down)
   );

   // ----------------------------------------------------------------
   // compare and report
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [17:0] e, input logic [17:0] g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic chk_bit(input string nm, input logic e, input logic g);
      cmp_count++;
      if (g !== e) begin
         fail_count++;
         $display("[FAIL] %s expected %b seen %b", nm, e, g);
      end
   endtask

   task automatic close_out();
      if (fail_count == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // one request through host p; reads checked against the reference array
   task automatic run(input int p, input dps_row_type r);
      logic [17:0] got [$];
      logic [17:0] msk;
      int          n;
      int          beats;
      int          a;
      n = 0;
      beats = (r.len == 8'h00) ? 1 : int'(r.len);
      msk = {{9{~r.ln[1]}}, {9{~r.ln[0]}}};
      @(negedge mclk);
      while (rdy[p] !== 1'b1 && n < 100) begin
         @(negedge mclk);
         n++;
      end
      if (n >= 100) begin
         fail_count++;
         close_out();
      end
      @(posedge mclk);
      rq[p] <= r;
      vld[p] <= 1'b1;
      @(posedge mclk);
      vld[p] <= 1'b0;
      while (dn[p] !== 1'b1 && n < 400) begin
         @(negedge mclk);
         n++;
         if (rv[p] === 1'b1) got.push_back(rd[p]);
      end
      if (n >= 400) begin
         fail_count++;
         close_out();
      end
      chk("beats", r.wr ? 18'h0 : 18'(beats), 18'(got.size()));
      if (r.wr) begin
         ref_mem[r.addr] = (ref_mem[r.addr] & ~msk) | (r.wd & msk);
      end else begin
         for (int k = 0; k < beats && k < got.size(); k++) begin
            a = ((r.clr ? 0 : int'(r.addr)) + k) % `DPS_DEPTH;
            chk("read word", ref_mem[a] & msk, got[k]);
         end
      end
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      vld = '{1'b0, 1'b0};
      rq = '{default: '0};
      repeat (8) @(posedge mclk);
      chk_bit("power_down", 1'b1, pif[0].power_down);
      chk_bit("req_ready", 1'b1, rdy[0]);
      chk_bit("left_busy", 1'b0, bsy[0]);
      sys_rst <= 1'b0;
      for (int i = 0; i < 12; i++) begin
         run(int'(rows[i].p), rows[i]);
      end
      // write on one port while the other reads, same cycles
      fork
         run(0, '{1'b0, 1'b1, 1'b0, 13'h0050, 18'h15a3c, 2'h0, 8'h00, 1'b0});
         run(1, '{1'b1, 1'b0, 1'b0, 13'h0011, 18'h00000, 2'h0, 8'h01, 1'b0});
      join
      run(1, '{1'b1, 1'b0, 1'b0, 13'h0050, 18'h00000, 2'h0, 8'h01, 1'b1});
      // second reset in mid-run; array contents survive it
      @(posedge mclk);
      sys_rst <= 1'b1;
      repeat (8) @(posedge mclk);
      chk_bit("dev_dq_oe idle", 1'b1, pif[1].dev_dq_oe == 2'b00);
      chk_bit("power_down", 1'b1, pif[1].power_down);
      chk_bit("right_busy", 1'b0, bsy[1]);
      sys_rst <= 1'b0;
      run(0, '{1'b0, 1'b0, 1'b0, 13'h0050, 18'h00000, 2'h0, 8'h01, 1'b0});
      close_out();
   end
endmodule

`default_nettype wire
